// >>> adc_cfg_pkg.sv
package adc_cfg_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_PAIR_POL = 8'h65;
  localparam logic [7:0] IDX_OFS_LOW = 8'h66;
  localparam logic [7:0] IDX_OFS_HIGH = 8'h67;
  localparam logic [7:0] IDX_FRAME_CTRL = 8'h68;
  localparam logic [7:0] IDX_RECAL_CTRL = 8'h6B;
  localparam logic [7:0] IDX_OUT_CLK = 8'h6D;
  localparam logic [7:0] IDX_CAL_STATUS = 8'hD1;
  // values after reset
  localparam logic [7:0] RST_PAIR_POL = 8'h00;
  localparam logic [7:0] RST_OFS_LOW = 8'h00;
  localparam logic [7:0] RST_OFS_HIGH = 8'h00;
  localparam logic [7:0] RST_FRAME_CTRL = 8'h24;
  localparam logic [7:0] RST_RECAL_CTRL = 8'h08;
  localparam logic [7:0] RST_OUT_CLK = 8'h00;
  // field positions
  localparam int POL_FIELD_LSB = 2;
  localparam int FRAME_INV_BIT = 3;
  localparam int FRAME_EN_BIT = 2;
  localparam int RECAL_TRIG_BIT = 2;
  localparam int PLL_CLK_EN_BIT = 5;
  localparam int VCO_DLY_LSB = 1;
  localparam logic [7:0] OUT_CLK_IMPL_MASK = 8'h3F;
  localparam int CAL_BUSY_BIT = 0;
  localparam int CAL_DONE_BIT = 1;
  // datapath widths
  localparam int SAMPLE_W = 12;
  localparam int PAIRS = 6;
  localparam int FRAC_BITS = 3;
  // calibration run time
  localparam int CLK_PERIOD_NS = 40;
  localparam int PLL_CAL_TIME_NS = 2560;
  localparam int PLL_CAL_CYCLES = PLL_CAL_TIME_NS / CLK_PERIOD_NS;
  localparam int CAL_CNT_W = 8;
endpackage

// >>> pll_cal_if.sv
`timescale 1ns/100ps
interface pll_cal_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport seq (input start, output busy, output done);
endinterface

// >>> pll_cal_seq.sv
`timescale 1ns/100ps
module pll_cal_seq (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // calibration handshake
  pll_cal_if.seq cal
);
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } cal_state_t;

  cal_state_t state_ff;
  logic [adc_cfg_pkg::CAL_CNT_W-1:0] count_ff;
  logic done_ff;

  // a new trigger restarts the run even mid-way
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= CAL_IDLE;
      count_ff <= '0;
    end else begin
      case (state_ff)
        CAL_IDLE: begin
          if (cal.start) begin
            state_ff <= CAL_RUN;
            count_ff <= adc_cfg_pkg::CAL_CNT_W'(adc_cfg_pkg::PLL_CAL_CYCLES - 1);
          end
        end
        CAL_RUN: begin
          if (cal.start) begin
            count_ff <= adc_cfg_pkg::CAL_CNT_W'(adc_cfg_pkg::PLL_CAL_CYCLES - 1);
          end else if (count_ff == '0) begin
            state_ff <= CAL_IDLE;
          end else begin
            count_ff <= count_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= CAL_IDLE;
        end
      endcase
    end
  end

  // done means the last run completed; a new start clears it
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      done_ff <= 1'b0;
    end else if (cal.start) begin
      done_ff <= 1'b0;
    end else if (state_ff == CAL_RUN && count_ff == '0) begin
      done_ff <= 1'b1;
    end
  end

  assign cal.busy = (state_ff == CAL_RUN);
  assign cal.done = done_ff;
endmodule

// >>> adc_output_offset_pll_ctrl.sv
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
module adc_output_offset_pll_ctrl (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // converter samples
  input wire logic [11:0] sample_in,
  input wire logic sample_valid_in,
  input wire logic sample_overrange_in,
  input wire logic frame_clock_in,
  // output mode and clock source state
  input wire logic lvds_mode_in,
  input wire logic pll_selected_in,
  input wire logic pll_enabled_in,
  // data pairs and frame/over-range pair
  output logic [11:0] data_pairs_out,
  output logic data_valid_out,
  output logic [1:0] frame_flag_pair_out,
  output logic frame_flag_pair_oe_out,
  // pll controls
  output logic pll_clk_enable_out,
  output logic [2:0] out_clock_vco_delay_out,
  output logic pll_cal_start_out,
  output logic pll_cal_busy_out
);
  // register images
  logic [7:0] pair_pol_ff;
  logic [7:0] ofs_low_ff;
  logic [7:0] ofs_high_ff;
  logic [7:0] frame_ctrl_ff;
  logic [7:0] recal_ctrl_ff;
  logic [7:0] out_clk_ff;

  // trigger and bus stages
  logic trig_seen_ff;
  logic start_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // output stages
  logic [11:0] pairs_ff;
  logic valid_ff;
  logic [1:0] frame_pair_ff;
  logic frame_oe_ff;
  logic pll_en_ff;
  logic [2:0] vco_dly_ff;
  logic cal_busy_ff;

  // decode and datapath nets
  logic [7:0] idx;
  logic req;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] nxt_rbyte;
  logic [11:0] nxt_sample;
  logic nxt_sat;
  logic [5:0] data_pair_invert;
  logic frame_flag_pair_invert;
  logic frame_flag_pair_enable;
  logic recal_trigger;

  pll_cal_if cal_bus ();

  pll_cal_seq u_cal (
    .clock_in (clock_in),
    .rst_in (rst_in),
    .cal (cal_bus.seq)
  );

  // offset add in eighth-LSb units, floor back to whole codes, clamp
  function automatic logic [12:0] offset_sat(input logic [11:0] s, input logic [15:0] o);
    logic signed [16:0] s_ext;
    logic signed [16:0] o_ext;
    logic signed [16:0] sum;
    logic signed [13:0] whole;
    s_ext = 17'(signed'({s[11], s, 3'h0}));
    o_ext = 17'(signed'({o[15], o}));
    sum = s_ext + o_ext;
    whole = 14'(sum >>> adc_cfg_pkg::FRAC_BITS);
    if (whole > 14'sh07FF) begin
      offset_sat = {1'b1, 12'h7FF};
    end else if (whole < -14'sh0800) begin
      offset_sat = {1'b1, 12'h800};
    end else begin
      offset_sat = {1'b0, whole[11:0]};
    end
  endfunction

  // flip each selected two-bit pair; mask bit p owns bits 2p+1:2p
  function automatic logic [11:0] invert_pairs(input logic [11:0] v, input logic [5:0] m);
    invert_pairs = v;
    for (int p = 0; p < adc_cfg_pkg::PAIRS; p++) begin
      if (m[p]) begin
        invert_pairs[2*p +: 2] = ~v[2*p +: 2];
      end
    end
  endfunction

  // bus decode: one request per cycle pair, ack drops after one cycle
  assign idx = wb_adr_in[9:2];
  assign req = wb_cyc_in && wb_stb_in && !ack_ff;
  assign wr = req && wb_we_in && wb_sel_in[0];
  assign wbyte = wb_dat_in[7:0];

  // field taps
  assign data_pair_invert = pair_pol_ff[7:adc_cfg_pkg::POL_FIELD_LSB];
  assign frame_flag_pair_invert = frame_ctrl_ff[adc_cfg_pkg::FRAME_INV_BIT];
  assign frame_flag_pair_enable = frame_ctrl_ff[adc_cfg_pkg::FRAME_EN_BIT];
  assign recal_trigger = recal_ctrl_ff[adc_cfg_pkg::RECAL_TRIG_BIT];

  // write strobe for one register index, shared by all six registers
  function automatic logic write_hit(input logic w, input logic [7:0] a, input logic [7:0] t);
    return w && (a == t);
  endfunction

  // pair polarity; the two low bits are stored but drive nothing
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pair_pol_ff <= adc_cfg_pkg::RST_PAIR_POL;
    end else if (write_hit(wr, idx, adc_cfg_pkg::IDX_PAIR_POL)) begin
      pair_pol_ff <= wbyte;
    end
  end

  // offset low byte; acts on its own write, no pairing latch
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ofs_low_ff <= adc_cfg_pkg::RST_OFS_LOW;
    end else if (write_hit(wr, idx, adc_cfg_pkg::IDX_OFS_LOW)) begin
      ofs_low_ff <= wbyte;
    end
  end

  // offset high byte, sign in its top bit
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ofs_high_ff <= adc_cfg_pkg::RST_OFS_HIGH;
    end else if (write_hit(wr, idx, adc_cfg_pkg::IDX_OFS_HIGH)) begin
      ofs_high_ff <= wbyte;
    end
  end

  // frame pair control; factory bits kept as written
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      frame_ctrl_ff <= adc_cfg_pkg::RST_FRAME_CTRL;
    end else if (write_hit(wr, idx, adc_cfg_pkg::IDX_FRAME_CTRL)) begin
      frame_ctrl_ff <= wbyte;
    end
  end

  // recalibration control; factory bits kept as written
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      recal_ctrl_ff <= adc_cfg_pkg::RST_RECAL_CTRL;
    end else if (write_hit(wr, idx, adc_cfg_pkg::IDX_RECAL_CTRL)) begin
      recal_ctrl_ff <= wbyte;
    end
  end

  // output clock register; unimplemented top bits never store
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      out_clk_ff <= adc_cfg_pkg::RST_OUT_CLK;
    end else if (write_hit(wr, idx, adc_cfg_pkg::IDX_OUT_CLK)) begin
      out_clk_ff <= wbyte & adc_cfg_pkg::OUT_CLK_IMPL_MASK;
    end
  end

  // read mux; unmapped and status-only bits read zero
  always_comb begin
    case (idx)
      adc_cfg_pkg::IDX_PAIR_POL: nxt_rbyte = pair_pol_ff;
      adc_cfg_pkg::IDX_OFS_LOW: nxt_rbyte = ofs_low_ff;
      adc_cfg_pkg::IDX_OFS_HIGH: nxt_rbyte = ofs_high_ff;
      adc_cfg_pkg::IDX_FRAME_CTRL: nxt_rbyte = frame_ctrl_ff;
      adc_cfg_pkg::IDX_RECAL_CTRL: nxt_rbyte = recal_ctrl_ff;
      adc_cfg_pkg::IDX_OUT_CLK: nxt_rbyte = out_clk_ff;
      adc_cfg_pkg::IDX_CAL_STATUS: begin
        nxt_rbyte = 8'h00;
        nxt_rbyte[adc_cfg_pkg::CAL_BUSY_BIT] = cal_bus.busy;
        nxt_rbyte[adc_cfg_pkg::CAL_DONE_BIT] = cal_bus.done;
      end
      default: nxt_rbyte = 8'h00;
    endcase
  end

  // ack one cycle after the request is seen, then low for a cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // read data captured with the ack, held until the next request
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req) begin
      rdat_ff <= {24'h00_0000, nxt_rbyte};
    end
  end

  // last seen trigger level; reset level matches the register, so no false start
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      trig_seen_ff <= adc_cfg_pkg::RST_RECAL_CTRL[adc_cfg_pkg::RECAL_TRIG_BIT];
    end else begin
      trig_seen_ff <= recal_trigger;
    end
  end

  // one-cycle start on any change of the trigger, both directions
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= (recal_trigger != trig_seen_ff);
    end
  end

  // sequencer sees the registered pulse, never the raw level
  assign cal_bus.start = start_ff;

  // calibration busy mirrored from the sequencer
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cal_busy_ff <= 1'b0;
    end else begin
      cal_busy_ff <= cal_bus.busy;
    end
  end

  // pll clock enable gated by clock source; ungated it would glitch the core clock
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pll_en_ff <= 1'b0;
    end else if (pll_selected_in && pll_enabled_in) begin
      pll_en_ff <= out_clk_ff[adc_cfg_pkg::PLL_CLK_EN_BIT];
    end else begin
      pll_en_ff <= 1'b0;
    end
  end

  // vco delay gated the same way as the enable
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      vco_dly_ff <= 3'h0;
    end else if (pll_selected_in && pll_enabled_in) begin
      vco_dly_ff <= out_clk_ff[adc_cfg_pkg::VCO_DLY_LSB +: 3];
    end else begin
      vco_dly_ff <= 3'h0;
    end
  end

  // sample path: offset, saturate, invert per pair
  always_comb begin
    logic [12:0] r;
    r = offset_sat(sample_in, {ofs_high_ff, ofs_low_ff});
    nxt_sat = r[12];
    nxt_sample = invert_pairs(r[11:0], data_pair_invert);
  end

  // valid is the input qualifier one cycle late
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= sample_valid_in;
    end
  end

  // data pairs hold between valid samples
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pairs_ff <= 12'h000;
    end else if (sample_valid_in) begin
      pairs_ff <= nxt_sample;
    end
  end

  // pair driven only while its enable bit is set
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      frame_oe_ff <= 1'b0;
    end else begin
      frame_oe_ff <= frame_flag_pair_enable;
    end
  end

  // frame/over-range pair: bit0 frame clock, bit1 over-range or saturation
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      frame_pair_ff <= 2'h0;
    end else if (!frame_flag_pair_enable) begin
      frame_pair_ff <= 2'h0;
    end else if (lvds_mode_in && frame_flag_pair_invert) begin
      frame_pair_ff <= ~{sample_overrange_in | nxt_sat, frame_clock_in};
    end else begin
      frame_pair_ff <= {sample_overrange_in | nxt_sat, frame_clock_in};
    end
  end

  assign wb_dat_out = rdat_ff;
  assign wb_ack_out = ack_ff;
  assign data_pairs_out = pairs_ff;
  assign data_valid_out = valid_ff;
  assign frame_flag_pair_out = frame_pair_ff;
  assign frame_flag_pair_oe_out = frame_oe_ff;
  assign pll_clk_enable_out = pll_en_ff;
  assign out_clock_vco_delay_out = vco_dly_ff;
  assign pll_cal_start_out = start_ff;
  assign pll_cal_busy_out = cal_busy_ff;
endmodule

// >>> adc_ctrl_checker_properties.sv
`timescale 1ns/100ps
module adc_ctrl_checker (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // sample path and frame pair
  input wire logic sample_valid_in,
  input wire logic data_valid_out,
  input wire logic [11:0] data_pairs_out,
  input wire logic [1:0] frame_flag_pair_out,
  input wire logic frame_flag_pair_oe_out,
  // pll controls
  input wire logic pll_selected_in,
  input wire logic pll_enabled_in,
  input wire logic pll_clk_enable_out,
  input wire logic [2:0] out_clock_vco_delay_out,
  input wire logic pll_cal_start_out,
  input wire logic pll_cal_busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // a run lasts tens of cycles, so eight is a safe floor
  sequence s_busy_run;
    pll_cal_busy_out [*8];
  endsequence
  property p_valid_follow;
    sample_valid_in |=> data_valid_out;
  endproperty
  a_valid_follow: assert property (p_valid_follow) else $error("valid not passed on");
  property p_data_hold;
    !sample_valid_in |=> $stable(data_pairs_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("pairs moved without sample");
  property p_oe_reset;
    $fell(rst_in) |=> frame_flag_pair_oe_out;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("frame pair off after reset");
  property p_oe_off_zero;
    !frame_flag_pair_oe_out |-> frame_flag_pair_out == 2'h0;
  endproperty
  a_oe_off_zero: assert property (p_oe_off_zero) else $error("disabled pair not low");
  property p_start_pulse;
    pll_cal_start_out |=> !pll_cal_start_out;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one");
  property p_start_busy;
    pll_cal_start_out |-> ##[1:3] pll_cal_busy_out;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy did not follow start");
  property p_busy_hold;
    $rose(pll_cal_busy_out) |-> s_busy_run;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  property p_pll_gate;
    !(pll_selected_in && pll_enabled_in) |=> !pll_clk_enable_out && out_clock_vco_delay_out == 3'h0;
  endproperty
  a_pll_gate: assert property (p_pll_gate) else $error("pll outputs not gated");
endmodule
bind adc_output_offset_pll_ctrl adc_ctrl_checker u_adc_ctrl_checker (
  .clock_in(clock_in), .rst_in(rst_in), .sample_valid_in(sample_valid_in),
  .data_valid_out(data_valid_out), .data_pairs_out(data_pairs_out),
  .frame_flag_pair_out(frame_flag_pair_out), .frame_flag_pair_oe_out(frame_flag_pair_oe_out),
  .pll_selected_in(pll_selected_in), .pll_enabled_in(pll_enabled_in),
  .pll_clk_enable_out(pll_clk_enable_out), .out_clock_vco_delay_out(out_clock_vco_delay_out),
  .pll_cal_start_out(pll_cal_start_out), .pll_cal_busy_out(pll_cal_busy_out));

// >>> lvds_host_model.sv
`timescale 1ns/100ps
module lvds_host_model (
  // clock
  input wire logic clock_in,
  // pairs from the converter
  input wire logic [11:0] data_pairs_in,
  input wire logic data_valid_in,
  // last word taken
  output logic [11:0] word_out
);
  // idle cycles never overwrite the captured word
  always_ff @(posedge clock_in) begin
    if (data_valid_in) begin
      word_out <= data_pairs_in;
    end
  end
endmodule

// >>> adc_output_offset_pll_ctrl_tb_top.sv
`timescale 1ns/100ps
module adc_output_offset_pll_ctrl_tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, vld = 1'b0, overrange_flag = 1'b0, frm = 1'b1;
  logic lvds = 1'b1, psel = 1'b1, pen = 1'b1, oe, dvo, ack, clk_en, cal_start, busy;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [11:0] smp = 12'h000;
  logic [11:0] dpo, hword;
  logic [1:0] fpo;
  logic [2:0] dly;
  logic [7:0] q;
  int err_total = 0;
  int checks_done = 0;
  logic [7:0] ridx [8] = '{8'h65, 8'h66, 8'h67, 8'h68, 8'h6B, 8'h6D, 8'hD1, 8'h10};
  logic [7:0] rval [8] = '{8'h00, 8'h00, 8'h00, 8'h24, 8'h08, 8'h00, 8'h00, 8'h00};
  logic [7:0] pol_tab [7] = '{8'h03, 8'h80, 8'h04, 8'h00, 8'h00, 8'h00, 8'hFC};
  logic [15:0] ofs_tab [7] = '{16'h0, 16'h0, 16'h8, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h10};
  logic [11:0] smp_tab [7] = '{12'h2A5, 12'h0, 12'h5, 12'h5, 12'h7FF, 12'h800, 12'h123};
  always #20 clock_in = ~clock_in;
  adc_output_offset_pll_ctrl u_adc_output_offset_pll_ctrl (
    .clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .sample_in(smp), .sample_valid_in(vld), .sample_overrange_in(overrange_flag), .frame_clock_in(frm),
    .lvds_mode_in(lvds), .pll_selected_in(psel), .pll_enabled_in(pen),
    .data_pairs_out(dpo), .data_valid_out(dvo), .frame_flag_pair_out(fpo),
    .frame_flag_pair_oe_out(oe), .pll_clk_enable_out(clk_en), .out_clock_vco_delay_out(dly),
    .pll_cal_start_out(cal_start), .pll_cal_busy_out(busy));
  lvds_host_model u_lvds_host_model (
    .clock_in(clock_in), .data_pairs_in(dpo), .data_valid_in(dvo), .word_out(hword));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; waits on ack, giving up and counting an error after 20 cycles
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] r);
    int n = 0;
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clock_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) err_total++;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  // floor of (sample plus eighth-steps), clamped, then pair inversion
  function automatic logic [11:0] model(input logic signed [11:0] s,
                                        input logic signed [15:0] o, input logic [5:0] pol);
    int v;
    logic [11:0] r;
    v = s;
    v = (v * 8 + o) >>> 3;
    if (v > 2047) v = 2047;
    if (v < -2048) v = -2048;
    r = v[11:0];
    for (int p = 0; p < 6; p++) if (pol[p]) r[2*p+:2] = ~r[2*p+:2];
    return r;
  endfunction
  task automatic samp(input logic [11:0] s, input logic [11:0] exp);
    @(posedge clock_in);
    smp <= s;
    vld <= 1'b1;
    @(posedge clock_in);
    vld <= 1'b0;
    @(posedge clock_in);
    #1 chk(dpo, exp);
    chk(hword, exp);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_in);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    foreach (ridx[i]) rd_chk(ridx[i], rval[i]);
    wr(8'h10, 8'h5A);
    rd_chk(8'h10, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(8'h65, pol_tab[i]);
      wr(8'h66, ofs_tab[i][7:0]);
      wr(8'h67, ofs_tab[i][15:8]);
      rd_chk(8'h67, ofs_tab[i][15:8]);
      samp(smp_tab[i], model(smp_tab[i], ofs_tab[i], pol_tab[i][7:2]));
      chk(fpo, (i == 4 || i == 5) ? 2'b11 : 2'b01);
    end
    chk({oe, fpo}, 3'b101);
    bus(1'b0, 8'h68, 8'h00, q);
    wr(8'h68, q | 8'h08);
    settle();
    chk({oe, fpo}, 3'b110);
    @(posedge clock_in);
    lvds <= 1'b0;
    overrange_flag <= 1'b1;
    settle();
    chk({oe, fpo}, 3'b111);
    wr(8'h68, q & 8'hFB);
    settle();
    chk({oe, fpo}, 3'b000);
    bus(1'b0, 8'h6B, 8'h00, q);
    for (int i = 0; i < 2; i++) begin
      q = q ^ 8'h04;
      wr(8'h6B, q);
      #1 chk(cal_start, 1'b1);
      rd_chk(8'hD1, 8'h01);
      #1 chk(busy, 1'b1);
      repeat (80) @(posedge clock_in);
      rd_chk(8'hD1, 8'h02);
      #1 chk(busy, 1'b0);
    end
    wr(8'h6B, q);
    repeat (3) begin
      #1 chk(cal_start, 1'b0);
      @(posedge clock_in);
    end
    wr(8'h6D, 8'hEE);
    rd_chk(8'h6D, 8'h2E);
    settle();
    chk({clk_en, dly}, 4'hF);
    @(posedge clock_in);
    pen <= 1'b0;
    settle();
    chk({clk_en, dly}, 4'h0);
    print_verdict();
  end
endmodule
